/* rtl/ublc_pkg.sv */
// Purpose: Shared constants for the UART baud, line and interrupt control block
// Assumes: Byte-wide register bus with 5-bit byte addresses
// Notes:   Offsets are byte addresses, one register per word
package ublc_pkg;
  // ==========================================================
  // Bus and register map
  localparam int unsigned ADDR_W   = 5;
  localparam int unsigned DATA_W   = 8;
  localparam logic [4:0]  OFF_BUF  = 5'h00;  // Rx/tx buffer or divisor low
  localparam logic [4:0]  OFF_IER  = 5'h04;  // Enables or divisor high
  localparam logic [4:0]  OFF_IIR  = 5'h08;
  localparam logic [4:0]  OFF_LCR  = 5'h0C;
  localparam logic [4:0]  OFF_LSR  = 5'h14;
  localparam logic [4:0]  OFF_MSR  = 5'h18;

  // ==========================================================
  // Reset values
  localparam logic [7:0] DLL_RST = 8'h01;
  localparam logic [7:0] DLM_RST = 8'h00;
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] LCR_RST = 8'h00;

  // ==========================================================
  // Field positions
  localparam int unsigned IER_RX   = 0;
  localparam int unsigned IER_TX   = 1;
  localparam int unsigned IER_LS   = 2;
  localparam int unsigned IER_MS   = 3;
  localparam int unsigned IER_USED = 4;  // Bits above read zero
  localparam int unsigned LCR_WLS  = 0;  // Two bits
  localparam int unsigned LCR_STB  = 2;
  localparam int unsigned LCR_PEN  = 3;
  localparam int unsigned LCR_EPS  = 4;
  localparam int unsigned LCR_SP   = 5;
  localparam int unsigned LCR_SB   = 6;
  localparam int unsigned LCR_DIVISOR_ACCESS_SEL = 7;

  // ==========================================================
  // Interrupt identification codes
  localparam logic [3:0] IID_NONE = 4'h1;
  localparam logic [3:0] IID_LS   = 4'h6;
  localparam logic [3:0] IID_RX   = 4'h4;
  localparam logic [3:0] IID_TO   = 4'hC;
  localparam logic [3:0] IID_THRE = 4'h2;
  localparam logic [3:0] IID_MS   = 4'h0;
  localparam logic [1:0] IIR_RSVD = 2'h0;
  localparam logic [1:0] IIR_MODE = 2'h3;  // Queue mode marker

  // ==========================================================
  // Baud generation and buffering
  localparam int unsigned OVERSAMPLE   = 16;
  localparam int unsigned OVS_W        = 4;
  localparam int unsigned DIV_W        = 16;
  localparam int unsigned TX_FIFO_DEPTH = 4;
endpackage

/* rtl/ublc_baud_gen.sv */
// Purpose: Baud generator, reference clock over divisor, then over sixteen
// Assumes: Divisor nonzero; zero behaves as a divisor of one
// Notes:   A new divisor is picked up at the next reload
`timescale 1ns/10ps
`default_nettype none
module ublc_baud_gen #(
  parameter int unsigned DIV_W = ublc_pkg::DIV_W
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  // Divisor
  input  wire logic [DIV_W-1:0] i_divisor,
  // Ticks
  output logic                  o_x16_tick,
  output logic                  o_baud_tick
);
  logic [DIV_W-1:0]            div_cnt_q, div_cnt_d;
  logic [ublc_pkg::OVS_W-1:0]  ovs_cnt_q, ovs_cnt_d;
  logic                        x16_d, baud_d;

  // ==========================================================
  // Two-stage divide
  always_comb begin
    div_cnt_d = div_cnt_q - 1'b1;
    ovs_cnt_d = ovs_cnt_q;
    x16_d     = 1'b0;
    baud_d    = 1'b0;
    if (div_cnt_q <= DIV_W'(1)) begin
      // Reload from the live divisor, so a change lands next period
      div_cnt_d = i_divisor;
      x16_d     = 1'b1;
      ovs_cnt_d = ovs_cnt_q + 1'b1;
      baud_d    = (ovs_cnt_q == ublc_pkg::OVS_W'(ublc_pkg::OVERSAMPLE - 1));
    end
  end

  // Registers only
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_cnt_q   <= '0;
      ovs_cnt_q   <= '0;
      o_x16_tick  <= 1'b0;
      o_baud_tick <= 1'b0;
    end else begin
      div_cnt_q   <= div_cnt_d;
      ovs_cnt_q   <= ovs_cnt_d;
      o_x16_tick  <= x16_d;
      o_baud_tick <= baud_d;
    end
  end
endmodule // ublc_baud_gen
`default_nettype wire

/* rtl/ublc_fifo.sv */
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Full and empty are registered flags
`timescale 1ns/10ps
`default_nettype none
module ublc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [PW:0]      cnt_q, cnt_d;
  logic             full_q, empty_q, push, pop;

  assign push        = i_in_valid && !full_q;
  assign pop         = i_out_ready && !empty_q;
  assign o_in_ready  = !full_q;
  assign o_out_valid = !empty_q;
  assign o_out_data  = mem[rd_q];

  // ==========================================================
  // Pointer and count update
  always_comb begin
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
  end

  // Registers only; storage carries no reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_q   <= '0;
      full_q  <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      cnt_q   <= cnt_d;
      full_q  <= (cnt_d == (PW+1)'(DEPTH));
      empty_q <= (cnt_d == '0);
    end
  end

  // Storage write
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end
endmodule // ublc_fifo
`default_nettype wire

/* rtl/ublc_top.sv */
// Purpose: UART baud, line format and interrupt control with register port
// Assumes: Rx/tx shift paths and status registers live outside, same clock
// Notes:   Read data is captured in the setup phase, side effects in access
// Summary of operation
// - Baud equals clock over sixteen times divisor
// - Divisor bytes reset to 01h and 00h
// - Enable bit 0 gates data and timeout
// - Enable bit 1 gates transmit empty
// - Enable bit 2 gates line errors
// - Enable bit 3 gates modem; upper zero
// - Ident low code, 00, then 11 on top
// - Line errors code 0110, cleared by status read
// - Data available code 0100, level driven
// - Timeout code 1100, cleared by buffer read
// - Transmit empty 0010, cleared by ident or write
// - Modem change 0000, cleared by modem read
// - Word length and stop bit selection
// - Parity enable and even or odd
// - Stick parity sends constant bit
// - Break forces serial output low
// - Access bit swaps first two locations
// - Divisor at offsets 00 and 04
`timescale 1ns/10ps
`default_nettype none
module ublc_top #(
  parameter int unsigned FIFO_DEPTH = ublc_pkg::TX_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // Register port
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [4:0]  i_paddr,
  input  wire logic [7:0]  i_pwdata,
  output logic      [7:0]  o_prdata,
  // Status from receive and modem logic
  input  wire logic [7:0]  i_rx_data,
  input  wire logic [7:0]  i_line_status,
  input  wire logic [7:0]  i_modem_status,
  input  wire logic        i_line_err,
  input  wire logic        i_rx_avail,
  input  wire logic        i_char_timeout,
  input  wire logic        i_modem_chg,
  output logic             o_rx_read,
  output logic             o_lsr_read,
  output logic             o_msr_read,
  // Transmit data towards the shifter
  output logic             o_tx_valid,
  output logic      [7:0]  o_tx_data,
  input  wire logic        i_tx_ready,
  output logic             o_thr_ready,
  input  wire logic        i_tx_serial,
  output logic             o_serial_out,
  // Format and timing to the shift paths
  output logic      [1:0]  o_word_length_sel,
  output logic             o_stop_bits_sel,
  output logic             o_parity_en,
  output logic             o_even_parity_sel,
  output logic             o_stick_parity_en,
  output logic             o_stick_bit,
  output logic             o_x16_tick,
  output logic             o_baud_clock,
  // Interrupt
  output logic             o_irq
);
  // ==========================================================
  // Declarations
  logic [7:0]  dll_q, dll_d, dlm_q, dlm_d, ier_q, ier_d, lcr_q, lcr_d;
  logic [7:0]  rdata_d;
  logic        ls_q, ls_d, to_q, to_d, thre_q, thre_d, ms_q, ms_d;
  logic        tx_empty_q, irq_d, serial_out_d, stick_d;
  logic        rx_rd_d, lsr_rd_d, msr_rd_d;
  logic [3:0]  iid;
  logic        setup, wr, rd, divisor_access_sel, thr_wr, iir_rd, tx_empty;
  logic        fifo_valid, fifo_in_ready;

  assign setup    = i_psel && !i_penable;
  assign wr       = i_psel && i_penable && i_pwrite;
  assign rd       = i_psel && i_penable && !i_pwrite;
  assign divisor_access_sel     = lcr_q[ublc_pkg::LCR_DIVISOR_ACCESS_SEL];
  assign thr_wr   = wr && (i_paddr == ublc_pkg::OFF_BUF) && !divisor_access_sel;
  assign iir_rd   = rd && (i_paddr == ublc_pkg::OFF_IIR);
  assign tx_empty = !fifo_valid;

  // ==========================================================
  // Baud generator
  // sixteen-times divide
  ublc_baud_gen #(
    .DIV_W (ublc_pkg::DIV_W)
  ) u_baud (
    .i_clk       (i_clk),
    .i_arst_n    (i_arst_n),
    .i_divisor   ({dlm_q, dll_q}),
    .o_x16_tick  (o_x16_tick),
    .o_baud_tick (o_baud_clock)
  );

  // ==========================================================
  // Transmit holding queue
  ublc_fifo #(
    .WIDTH (ublc_pkg::DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk       (i_clk),
    .i_arst_n    (i_arst_n),
    .i_in_valid  (thr_wr),
    .i_in_data   (i_pwdata),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (o_tx_data),
    .i_out_ready (i_tx_ready)
  );
  assign o_tx_valid  = fifo_valid;
  assign o_thr_ready = fifo_in_ready;  // Writes while full are dropped

  // ==========================================================
  // Register writes
  always_comb begin
    dll_d = dll_q;
    dlm_d = dlm_q;
    ier_d = ier_q;
    lcr_d = lcr_q;
    if (wr) begin
      unique case (i_paddr)
        ublc_pkg::OFF_BUF: begin
          if (divisor_access_sel) begin
            dll_d = i_pwdata;  // low byte
          end
        end
        ublc_pkg::OFF_IER: begin
          if (divisor_access_sel) begin
            dlm_d = i_pwdata;  // high byte
          end else begin
            ier_d = {{(8-ublc_pkg::IER_USED){1'b0}}, i_pwdata[ublc_pkg::IER_USED-1:0]};
          end
        end
        ublc_pkg::OFF_LCR: lcr_d = i_pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dll_q <= ublc_pkg::DLL_RST;
      dlm_q <= ublc_pkg::DLM_RST;
      ier_q <= ublc_pkg::IER_RST;
      lcr_q <= ublc_pkg::LCR_RST;
    end else begin
      dll_q <= dll_d;
      dlm_q <= dlm_d;
      ier_q <= ier_d;
      lcr_q <= lcr_d;
    end
  end

  // ==========================================================
  // Interrupt sources; a set always beats a clear in the same cycle
  always_comb begin
    ls_d = i_line_err || (ls_q && !(rd && i_paddr == ublc_pkg::OFF_LSR));
    to_d = i_char_timeout || (to_q && !(rd && i_paddr == ublc_pkg::OFF_BUF && !divisor_access_sel));
    ms_d = i_modem_chg || (ms_q && !(rd && i_paddr == ublc_pkg::OFF_MSR));
    // set on empty or on enabling, cleared by ident read or write
    thre_d = (tx_empty && !tx_empty_q)
          || (tx_empty && wr && !divisor_access_sel && i_paddr == ublc_pkg::OFF_IER
              && i_pwdata[ublc_pkg::IER_TX] && !ier_q[ublc_pkg::IER_TX])
          || (thre_q && !thr_wr && !(iir_rd && iid == ublc_pkg::IID_THRE));
  end

  always_comb begin
    if (ls_q && ier_q[ublc_pkg::IER_LS]) begin
      iid = ublc_pkg::IID_LS;
    end else if (i_rx_avail && ier_q[ublc_pkg::IER_RX]) begin
      iid = ublc_pkg::IID_RX;       // follows the level
    end else if (to_q && ier_q[ublc_pkg::IER_RX]) begin
      iid = ublc_pkg::IID_TO;
    end else if (thre_q && ier_q[ublc_pkg::IER_TX]) begin
      iid = ublc_pkg::IID_THRE;
    end else if (ms_q && ier_q[ublc_pkg::IER_MS]) begin
      iid = ublc_pkg::IID_MS;
    end else begin
      iid = ublc_pkg::IID_NONE;
    end
    irq_d = (iid != ublc_pkg::IID_NONE);
  end

  // Source registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ls_q       <= 1'b0;
      to_q       <= 1'b0;
      ms_q       <= 1'b0;
      thre_q     <= 1'b0;
      tx_empty_q <= 1'b1;
      o_irq      <= 1'b0;
    end else begin
      ls_q       <= ls_d;
      to_q       <= to_d;
      ms_q       <= ms_d;
      thre_q     <= thre_d;
      tx_empty_q <= tx_empty;
      o_irq      <= irq_d;
    end
  end

  // ==========================================================
  // Read data, captured in setup so it is stable in access
  always_comb begin
    rdata_d = o_prdata;
    if (setup) begin
      unique case (i_paddr)
        ublc_pkg::OFF_BUF: rdata_d = divisor_access_sel ? dll_q : i_rx_data;
        ublc_pkg::OFF_IER: rdata_d = divisor_access_sel ? dlm_q : ier_q;
        ublc_pkg::OFF_IIR: rdata_d = {ublc_pkg::IIR_MODE, ublc_pkg::IIR_RSVD, iid};
        ublc_pkg::OFF_LCR: rdata_d = lcr_q;
        ublc_pkg::OFF_LSR: rdata_d = i_line_status;
        ublc_pkg::OFF_MSR: rdata_d = i_modem_status;
        default:           rdata_d = 8'h00;  // Unmapped reads as zero
      endcase
    end
    rx_rd_d  = rd && i_paddr == ublc_pkg::OFF_BUF && !divisor_access_sel;
    lsr_rd_d = rd && i_paddr == ublc_pkg::OFF_LSR;
    msr_rd_d = rd && i_paddr == ublc_pkg::OFF_MSR;
  end

  // ==========================================================
  // Line format outputs
  always_comb begin
    serial_out_d  = lcr_q[ublc_pkg::LCR_SB] ? 1'b0 : i_tx_serial;
    // stick bit is inverse of even select
    stick_d = !lcr_q[ublc_pkg::LCR_EPS];
  end

  // Output registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_prdata          <= 8'h00;
      o_rx_read         <= 1'b0;
      o_lsr_read        <= 1'b0;
      o_msr_read        <= 1'b0;
      o_serial_out      <= 1'b1;
      o_word_length_sel <= 2'h0;
      o_stop_bits_sel   <= 1'b0;
      o_parity_en       <= 1'b0;
      o_even_parity_sel <= 1'b0;
      o_stick_parity_en <= 1'b0;
      o_stick_bit       <= 1'b1;
    end else begin
      o_prdata          <= rdata_d;
      o_rx_read         <= rx_rd_d;
      o_lsr_read        <= lsr_rd_d;
      o_msr_read        <= msr_rd_d;
      o_serial_out      <= serial_out_d;
      o_word_length_sel <= lcr_q[ublc_pkg::LCR_WLS +: 2];
      o_stop_bits_sel   <= lcr_q[ublc_pkg::LCR_STB];
      o_parity_en       <= lcr_q[ublc_pkg::LCR_PEN];
      o_even_parity_sel <= lcr_q[ublc_pkg::LCR_EPS];
      o_stick_parity_en <= lcr_q[ublc_pkg::LCR_SP];
      o_stick_bit       <= stick_d;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  property p_break_low;
    lcr_q[ublc_pkg::LCR_SB] |=> !o_serial_out;
  endproperty
  a_break_low: assert property (p_break_low) else $error("break not low");

  property p_ls_top;
    (ls_q && ier_q[ublc_pkg::IER_LS]) |-> iid == ublc_pkg::IID_LS;
  endproperty
  a_ls_top: assert property (p_ls_top) else $error("line status not top");

  property p_rx_masked;
    !ier_q[ublc_pkg::IER_RX] |-> iid != ublc_pkg::IID_RX && iid != ublc_pkg::IID_TO;
  endproperty
  a_rx_masked: assert property (p_rx_masked) else $error("rx not masked");

  property p_irq_follow;
    (iid != ublc_pkg::IID_NONE) |=> o_irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq missing");

  property p_ier_upper;
    ier_q[7:ublc_pkg::IER_USED] == '0;
  endproperty
  a_ier_upper: assert property (p_ier_upper) else $error("ier upper set");

  property p_thre_clear;
    (thr_wr && !(tx_empty && !tx_empty_q)) |=> !thre_q;
  endproperty
  a_thre_clear: assert property (p_thre_clear) else $error("thre kept");

  property p_ms_clear;
    (rd && i_paddr == ublc_pkg::OFF_MSR && !i_modem_chg) |=> !ms_q;
  endproperty
  a_ms_clear: assert property (p_ms_clear) else $error("modem kept");

  property p_div_write;
    (wr && divisor_access_sel && i_paddr == ublc_pkg::OFF_IER) |=> dlm_q == $past(i_pwdata) && ier_q == $past(ier_q);
  endproperty
  a_div_write: assert property (p_div_write) else $error("divisor swap");

  property p_iir_read;
    (setup && i_paddr == ublc_pkg::OFF_IIR) |=> o_prdata[7:4] == 4'hC;
  endproperty
  a_iir_read: assert property (p_iir_read) else $error("ident upper bits");

  c_break:  cover property (lcr_q[ublc_pkg::LCR_SB] ##1 !lcr_q[ublc_pkg::LCR_SB]);
  c_thre:   cover property (iid == ublc_pkg::IID_THRE ##1 iir_rd);
  c_full:   cover property (!fifo_in_ready && thr_wr);
  c_ls_irq: cover property (ls_q && o_irq);
endmodule // ublc_top
`default_nettype wire

/* tb/ublc_txsink.sv */
// Purpose: Drain side of the transmit queue, standing in for the shifter
// Assumes: Ready is the inverse of the stall input, set off the sampling edge
// Notes:   Logs first, last and count of bytes taken; idle line high
`timescale 1ns/10ps
`default_nettype none
module ublc_txsink (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // Queue head
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  input  wire logic       i_stall,
  output logic            o_ready,
  // Serial line and log
  output logic            o_serial,
  output logic      [7:0] o_count,
  output logic      [7:0] o_first,
  output logic      [7:0] o_last
);
  // ==========================================================
  // Handshake; stalls let the queue fill up to refusal
  assign o_ready  = !i_stall;
  assign o_serial = 1'b1;

  // Byte log, taken on valid and ready
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_count <= 8'h00;
      o_first <= 8'h00;
      o_last  <= 8'h00;
    end else if (i_valid && o_ready) begin
      if (o_count == 8'h00) o_first <= i_data;
      o_last  <= i_data;
      o_count <= o_count + 8'h01;
    end
  end
endmodule // ublc_txsink
`default_nettype wire

/* tb/uart_baud_line_irq_control_test.sv */
// Purpose: Self-checking bench for baud, line format and interrupt control
// Assumes: Inputs driven on the falling edge; register port two-phase
// Notes:   Divisor kept small so baud periods stay short
`timescale 1ns/10ps
`default_nettype none
module uart_baud_line_irq_control_test;
  // ==========================================================
  // Stimulus and observed signals
  logic       clk = 1'b0, arst_n = 1'b0, psel = 1'b0, parity_en = 1'b0, pwr = 1'b0;
  logic [4:0] paddr = 5'h00;
  logic [7:0] pwd = 8'h00;
  logic       lerr = 1'b0, rxav = 1'b0, tmo = 1'b0, mchg = 1'b0;
  logic       stall = 1'b1, sel = 1'b0;
  wire logic [7:0] prdata, txd, cnt, first, last;
  wire logic [1:0] word_length_sel;
  wire logic  txv, txr, tx_holding_reg, ser, serial_out, stb, par, even_parity_sel, sp, sbit, x16, baud, irq;
  wire logic  tk = sel ? baud : x16;
  int         miscompares = 0, n_tests = 0, cyc = 0;

  ublc_top ublc_top_i (
    .i_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(parity_en),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prdata),
    .i_rx_data(8'h5A), .i_line_status(8'h60), .i_modem_status(8'h33),
    .i_line_err(lerr), .i_rx_avail(rxav), .i_char_timeout(tmo),
    .i_modem_chg(mchg), .o_rx_read(), .o_lsr_read(), .o_msr_read(),
    .o_tx_valid(txv), .o_tx_data(txd), .i_tx_ready(txr), .o_thr_ready(tx_holding_reg),
    .i_tx_serial(ser), .o_serial_out(serial_out), .o_word_length_sel(word_length_sel),
    .o_stop_bits_sel(stb), .o_parity_en(par), .o_even_parity_sel(even_parity_sel),
    .o_stick_parity_en(sp), .o_stick_bit(sbit), .o_x16_tick(x16),
    .o_baud_clock(baud), .o_irq(irq));

  ublc_txsink ublc_txsink_i (
    .i_clk(clk), .i_arst_n(arst_n), .i_valid(txv), .i_data(txd),
    .i_stall(stall), .o_ready(txr), .o_serial(ser), .o_count(cnt),
    .o_first(first), .o_last(last));

  // ==========================================================
  // Clock, and a ceiling well above the longest baud measurement
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ==========================================================
  // Shared tasks
  task wrap_up;
    $display("Checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Setup then access; idle after so read side effects land
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    psel  = 1'b1;
    pwr   = w;
    paddr = a;
    pwd   = d;
    @(negedge clk);
    parity_en = 1'b1;
    @(negedge clk);
    q    = prdata;
    psel = 1'b0;
    parity_en  = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task rdc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, e});
  endtask

  // Counts cycles between tick pulses; third span is clean
  task meas(input logic s, input int exp);
    int n;
    sel = s;
    for (int p = 0; p < 3; p++) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (tk !== 1'b1 && n < 9000);
    end
    chk(16'(n), 16'(exp));
  endtask

  // ==========================================================
  // Scenarios
  task t_baud;
    wr(ublc_pkg::OFF_LCR, 8'h80);
    rdc(ublc_pkg::OFF_BUF, 8'h01);
    rdc(ublc_pkg::OFF_IER, 8'h00);
    meas(1'b1, 16);
    wr(ublc_pkg::OFF_BUF, 8'h02);
    wr(ublc_pkg::OFF_IER, 8'h01);
    rdc(ublc_pkg::OFF_BUF, 8'h02);
    meas(1'b0, 258);
    meas(1'b1, 4128);
    wr(ublc_pkg::OFF_LCR, 8'h00);
    rdc(ublc_pkg::OFF_BUF, 8'h5A);
    wr(ublc_pkg::OFF_IER, 8'hFF);
    rdc(ublc_pkg::OFF_IER, 8'h0F);
    wr(ublc_pkg::OFF_IER, 8'h00);
  endtask

  task t_lcr;
    for (int v = 0; v < 64; v++) begin
      wr(ublc_pkg::OFF_LCR, 8'(v));
      rdc(ublc_pkg::OFF_LCR, 8'(v));
      chk({9'h000, sbit, sp, even_parity_sel, par, stb, word_length_sel}, {9'h000, ~v[4], 6'(v)});
    end
    wr(ublc_pkg::OFF_LCR, 8'h40);
    chk({15'h0000, serial_out}, 16'h0000);
    wr(ublc_pkg::OFF_LCR, 8'h00);
    chk({15'h0000, serial_out}, 16'h0001);
  endtask

  task t_irq;
    // Line error while masked stays hidden
    lerr = 1'b1;
    @(negedge clk);
    lerr = 1'b0;
    rdc(ublc_pkg::OFF_IIR, 8'hC1);
    chk({15'h0000, irq}, 16'h0000);
    wr(ublc_pkg::OFF_IER, 8'h04);
    rdc(ublc_pkg::OFF_IIR, 8'hC6);
    chk({15'h0000, irq}, 16'h0001);
    // All sources at once, then peel off in priority order
    rxav = 1'b1;
    tmo  = 1'b1;
    mchg = 1'b1;
    @(negedge clk);
    tmo  = 1'b0;
    mchg = 1'b0;
    wr(ublc_pkg::OFF_IER, 8'h0F);
    rdc(ublc_pkg::OFF_IIR, 8'hC6);
    rdc(ublc_pkg::OFF_LSR, 8'h60);
    rdc(ublc_pkg::OFF_IIR, 8'hC4);
    rxav = 1'b0;
    rdc(ublc_pkg::OFF_IIR, 8'hCC);
    rdc(ublc_pkg::OFF_BUF, 8'h5A);
    rdc(ublc_pkg::OFF_IIR, 8'hC2);
    rdc(ublc_pkg::OFF_IIR, 8'hC0);
    rdc(ublc_pkg::OFF_MSR, 8'h33);
    rdc(ublc_pkg::OFF_IIR, 8'hC1);
    chk({15'h0000, irq}, 16'h0000);
  endtask

  task t_fifo;
    // Clear enables first so the transmit enable sees a 0 to 1 step
    wr(ublc_pkg::OFF_IER, 8'h00);
    wr(ublc_pkg::OFF_IER, 8'h02);
    chk({15'h0000, irq}, 16'h0001);
    for (int i = 1; i < 6; i++) begin
      wr(ublc_pkg::OFF_BUF, 8'(i * 17));
      chk({15'h0000, irq}, 16'h0000);
    end
    chk({15'h0000, tx_holding_reg}, 16'h0000);
    stall = 1'b0;
    repeat (8) @(negedge clk);
    chk({cnt, first}, 16'h0411);
    chk({8'h00, last}, 16'h0044);
    chk({15'h0000, tx_holding_reg}, 16'h0001);
    rdc(ublc_pkg::OFF_IIR, 8'hC2);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    rdc(ublc_pkg::OFF_IER, 8'h00);
    rdc(ublc_pkg::OFF_IIR, 8'hC1);
    rdc(ublc_pkg::OFF_LCR, 8'h00);
    t_baud();
    t_lcr();
    t_irq();
    t_fifo();
    wrap_up();
  end
endmodule // uart_baud_line_irq_control_test
`default_nettype wire
